// ==== rtl/control_timer.sv ====
/*
 Waveform core of the twelve bit control timer with its fault inputs.
 Assumes one clock serving as both counter and synchronizer clock, a
 register port with one-cycle strobes, and asynchronous event pins.
*/
`include "control_timer_params.svh"

module control_timer (
    input wire logic clk_i,
    input wire logic nrst_i,
    input control_timer_pkg::reg_req_t reg_req_i,
    output logic [31:0] rdata_o,
    input wire logic event_a_i,
    input wire logic event_b_i,
    output logic output_a_o,
    output logic output_b_o
);
    import control_timer_pkg::*;

    state_t q;
    state_t d;
    logic eoc;
    logic set_a;
    logic clr_a;
    logic set_b;
    logic clr_b;
    logic start;
    logic tick;
    logic [11:0] lim;
    cyc_state_t st_nxt;
    logic [1:0] proc;
    logic [1:0] fault;
    logic [1:0] wide;
    logic [1:0] asy;
    logic [1:0] raw;
    logic en_ready;

    assign raw = {event_b_i, event_a_i};

    // mode set that kills both outputs instead of only the own one
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            wide[i] = (q.evc[i].fmode >= `FAULT_WIDE_LO) &&
                      (q.evc[i].fmode <= `FAULT_WIDE_HI);
            // raw pin on purpose: override must not wait for the sync
            asy[i] = raw[i] & q.evc[i].async_det & q.evc[i].trig_en &
                     (q.evc[i].fmode != `FAULT_OFF);
        end
    end

    // gated by run: a disable drops the pins at once, not a cycle late
    assign output_a_o = q.run & q.out_a & ~q.kill_a & ~asy[0] &
                        ~(asy[1] & wide[1]);
    assign output_b_o = q.run & q.out_b & ~q.kill_b & ~asy[1] &
                        ~(asy[0] & wide[0]);
    assign rdata_o = q.rdata;
    assign en_ready = (q.en_s1 == q.en_ctl) && (q.en_s2 == q.en_ctl);

    // next state of the whole block
    always_comb begin
        d = q;
        eoc = 1'b0;
        set_a = 1'b0;
        clr_a = 1'b0;
        set_b = 1'b0;
        clr_b = 1'b0;
        tick = 1'b0;
        lim = q.b_e;
        st_nxt = q.st;
        proc = 2'b00;
        fault = 2'b00;

        // enable crosses into the counter side over two stages
        d.en_s1 = q.en_ctl;
        d.en_s2 = q.en_s1;
        d.en_s3 = q.en_s2;
        start = q.en_s2 & ~q.en_s3;

        // counting schemes; state only moves while running
        if (q.run) begin
            case (q.mode)
                WG_ONE: begin
                    eoc = (q.cnt == q.b_e);
                    d.cnt = eoc ? 12'h000 : q.cnt + 12'h001;
                    set_a = (q.cnt == q.a_s);
                    // end below start never finds a set output
                    clr_a = (q.cnt == q.a_e) && (q.a_e >= q.a_s);
                    set_b = (q.cnt == q.b_s);
                    clr_a = clr_a | eoc;
                    clr_b = eoc;
                    if (eoc) begin
                        st_nxt = DEAD_A;
                    end else if (q.st == DEAD_A && set_a) begin
                        st_nxt = ON_A;
                    end else if (q.st == ON_A && q.cnt == q.a_e) begin
                        st_nxt = DEAD_B;
                    end else if (q.st == DEAD_B && set_b) begin
                        st_nxt = ON_B;
                    end
                end
                WG_TWO: begin
                    // start above end is never met: ramp resets first
                    if (q.st == DEAD_A || q.st == ON_A) begin
                        lim = q.a_e;
                        set_a = (q.cnt == q.a_s) && (q.a_s != q.a_e);
                        clr_a = (q.cnt == lim);
                        st_nxt = clr_a ? DEAD_B : (set_a ? ON_A : q.st);
                    end else begin
                        set_b = (q.cnt == q.b_s) && (q.b_s != q.b_e);
                        clr_b = (q.cnt == lim);
                        eoc = clr_b;
                        st_nxt = clr_b ? DEAD_A : (set_b ? ON_B : q.st);
                    end
                    d.cnt = (q.cnt == lim) ? 12'h000 : q.cnt + 12'h001;
                end
                WG_FOUR: begin
                    case (q.st)
                        DEAD_A: lim = q.a_s;
                        ON_A: lim = q.a_e;
                        DEAD_B: lim = q.b_s;
                        default: lim = q.b_e;
                    endcase
                    if (q.cnt == lim) begin
                        d.cnt = 12'h000;
                        st_nxt = cyc_state_t'(q.st + 2'h1);
                        eoc = (q.st == ON_B);
                    end else begin
                        d.cnt = q.cnt + 12'h001;
                    end
                    set_a = (st_nxt == ON_A);
                    clr_a = ~set_a;
                    set_b = (st_nxt == ON_B);
                    clr_b = ~set_b;
                end
                default: begin
                    // dual slope; a_e is never looked at here
                    if (!q.dir_up) begin
                        set_a = (q.cnt == q.a_s);
                        clr_b = (q.cnt == q.b_s);
                        if (q.cnt == 12'h000) begin
                            d.dir_up = 1'b1;
                        end else begin
                            d.cnt = q.cnt - 12'h001;
                        end
                    end else begin
                        clr_a = (q.cnt == q.a_s);
                        set_b = (q.cnt == q.b_s);
                        if (q.cnt == q.b_e) begin
                            d.dir_up = 1'b0;
                            eoc = 1'b1;
                        end else begin
                            d.cnt = q.cnt + 12'h001;
                        end
                    end
                    if (set_a) begin
                        st_nxt = ON_A;
                    end else if (clr_a) begin
                        st_nxt = DEAD_B;
                    end else if (set_b) begin
                        st_nxt = ON_B;
                    end else if (clr_b || eoc) begin
                        st_nxt = DEAD_A;
                    end
                end
            endcase
            d.st = st_nxt;
            d.out_a = (q.out_a | set_a) & ~clr_a;
            d.out_b = (q.out_b | set_b) & ~clr_b;
        end

        // idle: preload the start point, hold outputs low
        if (!q.run) begin
            d.cnt = (q.mode == WG_DUAL) ? q.b_e : 12'h000;
            d.dir_up = 1'b0;
            d.st = DEAD_A;
            d.out_a = 1'b0;
            d.out_b = 1'b0;
            d.run = start;
        end else if (!q.en_s2) begin
            d.run = 1'b0;
            d.eoc_pend = 1'b0;
        end else if (eoc && q.eoc_pend) begin
            d.run = 1'b0;
            d.eoc_pend = 1'b0;
            d.en_ctl = 1'b0;
            d.out_a = 1'b0;
            d.out_b = 1'b0;
        end

        // input filter and processing per channel
        for (int i = 0; i < 2; i++) begin
            d.flt_cnt[i] = 3'h0;
            if (!q.evc[i].filter) begin
                d.flt_val[i] = q.ev_s2[i];
            end else if (q.ev_s2[i] != q.flt_val[i]) begin
                // short pulses drop the count before it completes
                if (q.flt_cnt[i] == `FILTER_CYCLES - 3'h1) begin
                    d.flt_val[i] = q.ev_s2[i];
                end else begin
                    d.flt_cnt[i] = q.flt_cnt[i] + 3'h1;
                end
            end
            proc[i] = q.evc[i].filter ? q.flt_val[i] : q.ev_s2[i];
            proc[i] = proc[i] & q.evc[i].trig_en;
            if (i == 0 && q.blank_act) begin
                proc[i] = 1'b0;
            end
            fault[i] = proc[i] & (q.evc[i].fmode != `FAULT_OFF);
            d.ev_prev[i] = proc[i];
            if (proc[i] && !q.ev_prev[i] && q.evc[i].action) begin
                d.cap[i] = q.cnt;
            end
        end
        d.ev_s1 = raw;
        d.ev_s2 = q.ev_s1;
        // registered kill gives the two to three cycle override delay
        d.kill_a = fault[0] | (fault[1] & wide[1]);
        d.kill_b = fault[1] | (fault[0] & wide[0]);

        // blanking on input A; the output event is not offered
        tick = (q.pre_cnt == (8'h01 << q.blank_pre) - 8'h01);
        if (q.blank_act) begin
            if (tick) begin
                d.pre_cnt = 8'h00;
                if (q.blank_cnt + 12'h001 >= q.blank_val) begin
                    d.blank_act = 1'b0;
                end else begin
                    d.blank_cnt = q.blank_cnt + 12'h001;
                end
            end else begin
                d.pre_cnt = q.pre_cnt + 8'h01;
            end
        end
        if (q.run && d.st != q.st && d.st == q.blank_trig &&
            q.blank_sel && q.blank_val != 12'h000) begin
            d.blank_act = 1'b1;
            d.blank_cnt = 12'h000;
            d.pre_cnt = 8'h00;
        end
        if (!q.blank_sel) begin
            d.blank_act = 1'b0;
        end

        // register writes; software set wins over hardware clear
        if (reg_req_i.wr) begin
            case (reg_req_i.addr)
                `OFF_CTRL: begin
                    d.en_ctl = reg_req_i.wdata[`CTRL_ENABLE_BIT];
                    d.mode = wave_mode_t'(reg_req_i.wdata[2:1]);
                end
                `OFF_CMD: begin
                    if (reg_req_i.wdata[`CMD_EOC_DISABLE_BIT] && q.run) begin
                        d.eoc_pend = 1'b1;
                    end
                end
                `OFF_A_ON_START: d.a_s = reg_req_i.wdata[11:0];
                `OFF_A_ON_END: d.a_e = reg_req_i.wdata[11:0];
                `OFF_B_ON_START: d.b_s = reg_req_i.wdata[11:0];
                `OFF_B_ON_END_TOP: d.b_e = reg_req_i.wdata[11:0];
                `OFF_EVENT_CONTROL_A: d.evc[0] = reg_req_i.wdata[7:0];
                `OFF_EVENT_CONTROL_B: d.evc[1] = reg_req_i.wdata[7:0];
                `OFF_BLANK_CONTROL: begin
                    d.blank_sel = reg_req_i.wdata[0];
                    d.blank_trig = cyc_state_t'(reg_req_i.wdata[2:1]);
                    d.blank_pre = reg_req_i.wdata[4:3];
                end
                `OFF_BLANK_VALUE: d.blank_val = reg_req_i.wdata[11:0];
                default: begin
                end
            endcase
        end

        // read data stands only in the cycle after the strobe
        d.rdata = 32'h0000_0000;
        if (reg_req_i.rd) begin
            case (reg_req_i.addr)
                `OFF_CTRL: d.rdata = {29'h0, q.mode, q.en_ctl};
                `OFF_STATUS: d.rdata = {24'h0, q.eoc_pend, q.out_b,
                                        q.out_a, q.dir_up, q.st, q.run,
                                        en_ready};
                `OFF_A_ON_START: d.rdata = {20'h0, q.a_s};
                `OFF_A_ON_END: d.rdata = {20'h0, q.a_e};
                `OFF_B_ON_START: d.rdata = {20'h0, q.b_s};
                `OFF_B_ON_END_TOP: d.rdata = {20'h0, q.b_e};
                `OFF_EVENT_CONTROL_A: d.rdata = {24'h0, q.evc[0]};
                `OFF_EVENT_CONTROL_B: d.rdata = {24'h0, q.evc[1]};
                `OFF_BLANK_CONTROL: d.rdata = {27'h0, q.blank_pre,
                                               q.blank_trig, q.blank_sel};
                `OFF_BLANK_VALUE: d.rdata = {20'h0, q.blank_val};
                `OFF_CAPTURE_A: d.rdata = {20'h0, q.cap[0]};
                `OFF_CAPTURE_B: d.rdata = {20'h0, q.cap[1]};
                `OFF_COUNT: d.rdata = {20'h0, q.cnt};
                default: d.rdata = 32'h0000_0000;
            endcase
        end
    end

    // single state register
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            q <= '0;
            q.a_s <= `RST_CMP;
            q.a_e <= `RST_CMP;
            q.b_s <= `RST_CMP;
            q.b_e <= `RST_CMP;
        end else begin
            q <= d;
        end
    end

    // checks
    sequence s_dual_bottom;
        q.run && q.mode == WG_DUAL && !q.dir_up && q.cnt == 12'h000;
    endsequence

    sequence s_dual_turned;
        q.dir_up && q.cnt == 12'h000;
    endsequence

    AST_ONE_WRAP: assert property (@(posedge clk_i) disable iff (!nrst_i)
        q.run && q.en_s2 && !q.eoc_pend && q.mode == WG_ONE &&
        q.cnt == q.b_e |=> q.cnt == 12'h000 && q.st == DEAD_A)
        else $error("one ramp did not wrap at top");

    AST_TOP_CLEAR: assert property (@(posedge clk_i) disable iff (!nrst_i)
        q.run && q.mode == WG_ONE && q.cnt == q.b_e
        |=> !q.out_a && !q.out_b)
        else $error("top match did not clear outputs");

    AST_TWO_RAMP: assert property (@(posedge clk_i) disable iff (!nrst_i)
        q.run && q.en_s2 && q.mode == WG_TWO && q.st == ON_A &&
        q.cnt == q.a_e |=> q.cnt == 12'h000 && q.st == DEAD_B)
        else $error("two ramp first half did not reset");

    AST_FOUR_STEP: assert property (@(posedge clk_i) disable iff (!nrst_i)
        q.run && q.en_s2 && !q.eoc_pend && q.mode == WG_FOUR &&
        q.st == DEAD_B && q.cnt == q.b_s
        |=> q.cnt == 12'h000 && q.st == ON_B && q.out_b)
        else $error("four ramp step wrong");

    AST_DUAL_TURN: assert property (@(posedge clk_i) disable iff (!nrst_i)
        s_dual_bottom and q.en_s2 |=> s_dual_turned)
        else $error("dual slope did not turn at zero");

    AST_DUAL_A: assert property (@(posedge clk_i) disable iff (!nrst_i)
        q.run && q.en_s2 && q.mode == WG_DUAL && !q.dir_up &&
        q.cnt == q.a_s |=> q.out_a ##1 q.out_a || q.cnt == q.a_s)
        else $error("output_a not set on downward match");

    AST_DUAL_B: assert property (@(posedge clk_i) disable iff (!nrst_i)
        q.run && q.en_s2 && !q.eoc_pend && q.mode == WG_DUAL &&
        q.dir_up && q.cnt == q.b_s && q.b_s != q.b_e |=> q.out_b)
        else $error("output_b not set on upward match");

    AST_DUAL_START: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !q.run && start && q.mode == WG_DUAL |=> q.cnt == $past(q.b_e)
        && !q.dir_up && !q.out_b)
        else $error("dual slope start point wrong");

    AST_EN_OFF: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $fell(q.en_ctl) |-> ##[1:3] !q.run)
        else $error("timer still running after disable");

    AST_EOC_OFF: assert property (@(posedge clk_i) disable iff (!nrst_i)
        q.run && eoc && q.eoc_pend |=> !q.run && !q.en_ctl)
        else $error("end of cycle disable missed");

    AST_IDLE_LOW: assert property (@(posedge clk_i) disable iff (!nrst_i)
        !q.run && $past(!q.run) |-> !q.out_a && !q.out_b)
        else $error("output active while disabled");

    AST_SYNC_KILL: assert property (@(posedge clk_i) disable iff (!nrst_i)
        q.ev_s2[0] && !q.evc[0].filter && q.evc[0].trig_en &&
        q.evc[0].fmode != `FAULT_OFF && !q.blank_act |=> !output_a_o)
        else $error("synchronous override too late");
endmodule

// ==== rtl/control_timer_params.svh ====
/*
 Constants of the waveform timer: register offsets, field positions,
 reset values and timing counts. Assumes byte addresses on an 8-bit bus.
*/
// Summary of operation
// - cycle walks dead A, on A, dead B, on B, ended by the four compares
// - one ramp counts 0 to b_on_end_top, period top plus one
// - one ramp top clears both; compares above top or reversed end do nothing
// - two ramp counts to a_on_end, resets, then to b_on_end_top
// - two ramp start above end is never reached, no overlap
// - four ramp runs four ramps ending at each compare in turn
// - dual slope counts top down to zero and back up
// - dual slope output_a set matching downward, cleared matching upward
// - dual slope output_b set matching upward, cleared matching downward
// - dual slope ignores a_on_end
// - dual slope starts at top counting down, output_b waits
// - enable written 0 stops timer once synchronised
// - end_of_cycle_disable stops timer at end of current cycle
// - two event inputs, each acts only with trigger_input_enable set
// - enabled input is fault detect; action bit adds capture; mode 0 off
// - both inputs share fault modes; blanking on input A only
// - synchronous override after two to three cycles; async acts at once
// - blank_select enables blanking, blank_trigger starts it, runs to value
// - blanking tick is clock divided by blank_prescale factor
// - blanking and programmable output event share logic; only blanking here
// - filter rejects pulses under four cycles, delays changes four cycles
// - asynchronous detection selected in the event control register
// - fault mode 0 leaves outputs alone, capture still works
`ifndef CONTROL_TIMER_PARAMS_SVH
`define CONTROL_TIMER_PARAMS_SVH
`define OFF_CTRL 8'h00
`define OFF_CMD 8'h04
`define OFF_STATUS 8'h08
`define OFF_A_ON_START 8'h0C
`define OFF_A_ON_END 8'h10
`define OFF_B_ON_START 8'h14
`define OFF_B_ON_END_TOP 8'h18
`define OFF_EVENT_CONTROL_A 8'h1C
`define OFF_EVENT_CONTROL_B 8'h20
`define OFF_BLANK_CONTROL 8'h24
`define OFF_BLANK_VALUE 8'h28
`define OFF_CAPTURE_A 8'h2C
`define OFF_CAPTURE_B 8'h30
`define OFF_COUNT 8'h34
`define CTRL_ENABLE_BIT 0
`define CMD_EOC_DISABLE_BIT 0
`define RST_CMP 12'h000
`define FILTER_CYCLES 3'h4
`define FAULT_OFF 4'h0
`define FAULT_WIDE_LO 4'h4
`define FAULT_WIDE_HI 4'h7
`endif

// ==== rtl/control_timer_pkg.sv ====
/*
 Types of the waveform timer: modes, cycle states, event settings,
 register request and the whole state record. Assumes nothing further.
*/
package control_timer_pkg;
    typedef enum logic [1:0] {WG_ONE, WG_TWO, WG_FOUR, WG_DUAL} wave_mode_t;
    typedef enum logic [1:0] {DEAD_A, ON_A, DEAD_B, ON_B} cyc_state_t;
    typedef struct packed {
        logic [3:0] fmode;
        logic async_det;
        logic filter;
        logic action;
        logic trig_en;
    } ev_cfg_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
    typedef struct packed {
        logic [11:0] cnt;
        cyc_state_t st;
        logic dir_up;
        logic run;
        logic out_a;
        logic out_b;
        logic en_ctl;
        logic en_s1;
        logic en_s2;
        logic en_s3;
        logic eoc_pend;
        wave_mode_t mode;
        logic [11:0] a_s;
        logic [11:0] a_e;
        logic [11:0] b_s;
        logic [11:0] b_e;
        ev_cfg_t [1:0] evc;
        logic [1:0] ev_s1;
        logic [1:0] ev_s2;
        logic [1:0] flt_val;
        logic [1:0][2:0] flt_cnt;
        logic [1:0] ev_prev;
        logic kill_a;
        logic kill_b;
        logic blank_sel;
        cyc_state_t blank_trig;
        logic [1:0] blank_pre;
        logic [11:0] blank_val;
        logic blank_act;
        logic [7:0] pre_cnt;
        logic [11:0] blank_cnt;
        logic [1:0][11:0] cap;
        logic [31:0] rdata;
    } state_t;
endpackage

// ==== test/event_net.sv ====
/*
 Model of the event routing network that feeds the timer's two inputs.
 Assumes the bench asks for level changes through set_level.
*/
module event_net (
    input wire logic clk_i,
    output logic event_a_o,
    output logic event_b_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // routed events are plain levels, low until asked for
    initial begin
        event_a_o = 1'b0;
        event_b_o = 1'b0;
    end
    // level changes just after an edge, as a clocked router would
    task automatic set_level(input logic ch, input logic v);
        @(posedge clk_i);
        if (ch)
            event_b_o <= v;
        else
            event_a_o <= v;
    endtask
endmodule

// ==== test/tb_top.sv ====
/*
 Self-checking bench of the waveform timer: counting schemes, disabling
 and event overrides. Assumes the register map and timing of the design.
*/
`include "control_timer_params.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import control_timer_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    reg_req_t req = '0;
    logic [31:0] rdata;
    logic ev_a, ev_b, out_a, out_b;
    int fails = 0;
    int n_checks = 0;

    // 250 MHz clock
    always #2 clk = ~clk;

    control_timer u_control_timer (.clk_i(clk), .nrst_i(nrst),
        .reg_req_i(req), .rdata_o(rdata), .event_a_i(ev_a),
        .event_b_i(ev_b), .output_a_o(out_a), .output_b_o(out_b));
    event_net u_event_net (.clk_i(clk), .event_a_o(ev_a), .event_b_o(ev_b));

    task automatic give_verdict();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, exp, input string what);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s %h not %h", $time, what, got, exp);
        end
    endtask
    // bus cycles: strobe for one cycle, read data the cycle after
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        #1 d = rdata;
    endtask
    // enable only changes while the ready flag is up
    task automatic set_ctrl(input logic [31:0] v);
        logic [31:0] s;
        int n;
        s = '0;
        for (n = 0; n < 20 && s[0] !== 1'b1; n++)
            rd(`OFF_STATUS, s);
        check(s[0], 1'b1, "enable ready");
        wr(`OFF_CTRL, v);
    endtask
    task automatic cmp(input logic [11:0] s_a, e_a, s_b, top);
        wr(`OFF_A_ON_START, s_a);
        wr(`OFF_A_ON_END, e_a);
        wr(`OFF_B_ON_START, s_b);
        wr(`OFF_B_ON_END_TOP, top);
    endtask
    // bounded wait for a level on one output, sampled after each edge
    task automatic wait_lvl(input logic sel, input logic v, output int n);
        for (n = 0; (sel ? out_b : out_a) !== v; n++) begin
            @(posedge clk);
            #1;
            if (n > 300) begin
                fails++;
                give_verdict();
            end
        end
    endtask
    task automatic measure(input logic sel, output int p, output int w);
        int n;
        wait_lvl(sel, 1'b0, n);
        wait_lvl(sel, 1'b1, n);
        wait_lvl(sel, 1'b0, w);
        wait_lvl(sel, 1'b1, n);
        p = w + n;
    endtask

    task automatic t_reset();
        logic [31:0] d;
        check(out_a | out_b, 1'b0, "outputs idle");
        rd(`OFF_B_ON_END_TOP, d);
        check(d, 32'h0, "top after reset");
        rd(8'h3C, d);
        check(d, 32'h0, "unmapped read");
    endtask
    // one, two and four ramp with the same ascending compares
    task automatic t_ramps();
        int p, w;
        int ep[3] = '{12, 18, 30};
        int ew[3] = '{3, 3, 6};
        cmp(12'h002, 12'h005, 12'h008, 12'h00B);
        for (int m = 0; m < 3; m++) begin
            set_ctrl({29'h0, m[1:0], 1'b1});
            measure(1'b0, p, w);
            check(p, ep[m], "ramp period");
            check(w, ew[m], "on time a");
            set_ctrl(32'h0);
            repeat (4) @(posedge clk);
            #1;
            check(out_a | out_b, 1'b0, "low after disable");
        end
    endtask
    task automatic t_dual();
        int p, w, n;
        logic [31:0] d;
        cmp(12'h003, 12'h007, 12'h006, 12'h00B);
        set_ctrl(32'h7);
        wait_lvl(1'b0, 1'b1, n);
        check(out_b, 1'b0, "b held first cycle");
        measure(1'b0, p, w);
        check(p, 24, "dual period");
        check(w, 7, "a set down clear up");
        wr(`OFF_A_ON_END, 32'h1);
        measure(1'b1, p, w);
        check(w, 11, "b set up clear down");
        measure(1'b0, p, w);
        check(w, 7, "a_on_end unused");
        wr(`OFF_CMD, 32'h1);
        rd(`OFF_STATUS, d);
        check(d[1], 1'b1, "runs to cycle end");
        repeat (24) @(posedge clk);
        rd(`OFF_STATUS, d);
        check(d[1:0], 2'b01, "stopped at cycle end");
        check(out_a | out_b, 1'b0, "low when stopped");
    endtask
    // async and filter never set together on one input
    task automatic t_fault();
        logic [7:0] cfg[6] = '{8'h40, 8'h03, 8'h45, 8'h41, 8'h49, 8'h41};
        logic [7:0] ex[6] = '{8'hFF, 8'hFF, 8'hFF, 8'h07, 8'h00, 8'hFF};
        int len[6] = '{6, 6, 3, 6, 6, 6};
        int n;
        logic [31:0] d;
        cmp(12'h002, 12'h028, 12'h032, 12'h03C);
        for (int i = 0; i < 6; i++) begin
            wr(`OFF_EVENT_CONTROL_A, cfg[i]);
            // last row: blanking from entry to on time a, 2 x 10 cycles
            if (i == 5) begin
                wr(`OFF_BLANK_CONTROL, 32'h0B);
                wr(`OFF_BLANK_VALUE, 32'h0A);
            end
            set_ctrl(32'h1);
            wait_lvl(1'b0, 1'b0, n);
            wait_lvl(1'b0, 1'b1, n);
            for (int k = 0; k < 8; k++) begin
                if (k == 0)
                    u_event_net.set_level(1'b0, 1'b1);
                else if (k == len[i])
                    u_event_net.set_level(1'b0, 1'b0);
                else
                    @(posedge clk);
                #1;
                check(out_a, ex[i][k], "override");
            end
            // mode 0 row also captures: count 6 at the processed edge
            if (i == 1) begin
                rd(`OFF_CAPTURE_A, d);
                check(d, 32'h6, "capture count");
            end
            set_ctrl(32'h0);
        end
        // input B in a both-output mode also kills output_a
        wr(`OFF_EVENT_CONTROL_B, 32'h41);
        set_ctrl(32'h1);
        wait_lvl(1'b0, 1'b0, n);
        wait_lvl(1'b0, 1'b1, n);
        u_event_net.set_level(1'b1, 1'b1);
        repeat (3) @(posedge clk);
        #1;
        check(out_a, 1'b0, "input b override");
        u_event_net.set_level(1'b1, 1'b0);
        set_ctrl(32'h0);
    endtask

    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_ramps();
        t_dual();
        t_fault();
        give_verdict();
    end
endmodule
